// ===== ssbs_pkg.sv
// Shared constants and types for the speed status and brake sequencer
package ssbs_pkg;

  // ----------------------------------------------------------------
  // Parameter indices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_ZERO_THR = 16'h2434;
  localparam logic [15:0] IDX_MATCH_WIN = 16'h2435;
  localparam logic [15:0] IDX_ARRIVAL_THR = 16'h2436;
  localparam logic [15:0] IDX_STILL_DLY = 16'h2437;
  localparam logic [15:0] IDX_RUN_DLY = 16'h2438;
  localparam logic [15:0] IDX_ENGAGE_SPD = 16'h2439;
  localparam logic [15:0] IDX_ESTOP_MODE = 16'h2443;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ZERO_THR = 16'h0032;
  localparam logic [15:0] RST_MATCH_WIN = 16'h0032;
  localparam logic [15:0] RST_ARRIVAL_THR = 16'h03e8;
  localparam logic [15:0] RST_STILL_DLY = 16'h0000;
  localparam logic [15:0] RST_RUN_DLY = 16'h0000;
  localparam logic [15:0] RST_ENGAGE_SPD = 16'h001e;
  localparam logic RST_ESTOP_MODE = 1'b0;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int ESTOP_MODE_BIT = 0;
  localparam logic ESTOP_MODE_ALARM = 1'b0;
  localparam logic ESTOP_MODE_KEEP = 1'b1;

  // ----------------------------------------------------------------
  // Speed and timing constants
  // ----------------------------------------------------------------
  localparam logic [16:0] HYST_RPM = 17'h0_000a;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MS_PS = 1000000000;
  localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;

  // Comparator order in the flag generate loop
  localparam int CMP_ZERO = 0;
  localparam int CMP_MATCH = 1;
  localparam int CMP_ARRIVAL = 2;
  localparam int CMP_COUNT = 3;
  localparam logic [2:0] CMP_RISING = 3'h4;

  typedef enum logic [1:0] {
    SSBS_ST_OFF = 2'b00,
    SSBS_ST_ON = 2'b01,
    SSBS_ST_STILL_HOLD = 2'b10,
    SSBS_ST_RUN_WAIT = 2'b11
  } ssbs_state_type;

endpackage

// ===== ssbs_hyst_cmp.sv
// Speed comparator with separate switch-on and switch-off levels
`timescale 1ns/1ps
module ssbs_hyst_cmp #(
  parameter int WIDTH = 17,
  parameter bit RISING = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic update_in,
  input wire logic [WIDTH-1:0] value_in,
  input wire logic [WIDTH-1:0] on_lvl_in,
  input wire logic [WIDTH-1:0] off_lvl_in,
  output logic flag_out
);

  typedef struct packed {
    logic flag;
  } ssbs_cmp_state_type;

  ssbs_cmp_state_type s_reg;
  ssbs_cmp_state_type s_next;

  // Falling: on at or below on level, off above off level.
  // Rising: on above on level, off below off level.
  always_comb begin
    s_next = s_reg;
    if (update_in) begin
      if (RISING) begin
        if (value_in > on_lvl_in) begin
          s_next.flag = 1'b1;
        end else if (value_in < off_lvl_in) begin
          s_next.flag = 1'b0;
        end
      end else begin
        if (value_in <= on_lvl_in) begin
          s_next.flag = 1'b1;
        end else if (value_in > off_lvl_in) begin
          s_next.flag = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flag_out = s_reg.flag;

endmodule // ssbs_hyst_cmp

// ===== ssbs_ms_timer.sv
// Millisecond delay timer with start and abort
`timescale 1ns/1ps
module ssbs_ms_timer #(
  parameter int CYC_PER_MS = 40000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [15:0] ms_in,
  output logic done_out
);

  localparam int CW = $clog2(CYC_PER_MS + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);

  typedef struct packed {
    logic run;
    logic done;
    logic [15:0] ms_left;
    logic [CW-1:0] cyc;
  } ssbs_tmr_state_type;

  ssbs_tmr_state_type s_reg;
  ssbs_tmr_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (abort_in) begin
      s_next = '0;
    end else if (start_in) begin
      s_next.run = 1'b1;
      s_next.done = (ms_in == 16'h0000);
      s_next.ms_left = ms_in;
      s_next.cyc = '0;
    end else if (s_reg.run && !s_reg.done) begin
      if (s_reg.cyc == CYC_LAST) begin
        s_next.cyc = '0;
        s_next.ms_left = s_reg.ms_left - 16'h0001;
        s_next.done = (s_reg.ms_left == 16'h0001);
      end else begin
        s_next.cyc = s_reg.cyc + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_out = s_reg.done;

endmodule // ssbs_ms_timer

// ===== ssbs_sequencer.sv
// Speed status flags, servo-off brake sequencing and emergency stop
//
// Contract
// - Zero-speed flag when speed below threshold
// - Zero-speed compare uses speed magnitude
// - Zero-speed compare has 10 rpm hysteresis
// - Coincidence flag when command error within window
// - Coincidence on at window-10, off above window+10
// - Arrival_speed_flag flag when speed exceeds threshold
// - Arrival_speed_flag compare has 10 rpm hysteresis
// - Standstill off: brake first, delayed de-energise
// - Running off: timed delay before brake engages
// - Running off: brake at earlier of delay, speed
// - Brake speed threshold; de-energise together with brake
// - E-stop mode 0: stop, disable, alarm
// - E-stop mode 1: stop, stay enabled, no alarm
`timescale 1ns/1ps
module ssbs_sequencer #(
  parameter int CYC_PER_MS = ssbs_pkg::CYC_PER_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic signed [15:0] speed_in,
  input wire logic signed [15:0] speed_cmd_in,
  input wire logic speed_sample_in,
  input wire logic servo_on_input_in,
  input wire logic estop_in,
  input wire logic [15:0] param_index_in,
  input wire logic [15:0] param_wdata_in,
  input wire logic param_write_in,
  input wire logic param_read_in,
  output logic [15:0] param_rdata_out,
  output logic param_ack_out,
  output logic zero_speed_flag_out,
  output logic alt_zero_speed_output_out,
  output logic speed_match_flag_out,
  output logic arrival_speed_flag_out,
  output logic brake_release_output_out,
  output logic motor_energise_out,
  output logic forced_stop_out,
  output logic emergency_stop_alarm_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ssbs_pkg::ssbs_state_type state;
    logic [15:0] zero_speed_threshold;
    logic [15:0] speed_match_window;
    logic [15:0] arrival_speed_threshold;
    logic [15:0] standstill_brake_delay;
    logic [15:0] running_brake_delay;
    logic [15:0] brake_engage_speed;
    logic estop_mode;
    logic brake_rel;
    logic energise;
    logic fstop;
    logic alarm;
    logic alt_zero;
    logic [15:0] rdata;
    logic ack;
  } ssbs_top_state_type;

  ssbs_top_state_type s_reg;
  ssbs_top_state_type s_next;

  logic [16:0] abs_speed;
  logic [16:0] abs_error;
  logic signed [16:0] error_wide;
  logic [16:0] cmp_value [ssbs_pkg::CMP_COUNT];
  logic [16:0] cmp_on [ssbs_pkg::CMP_COUNT];
  logic [16:0] cmp_off [ssbs_pkg::CMP_COUNT];
  logic [ssbs_pkg::CMP_COUNT-1:0] cmp_flag;
  logic tmr_start;
  logic tmr_abort;
  logic [15:0] tmr_ms;
  logic tmr_done;
  logic servo_req;
  logic below_engage;

  function automatic logic [16:0] abs17(input logic signed [16:0] v);
    abs17 = v[16] ? 17'(-v) : 17'(v);
  endfunction

  function automatic logic [16:0] sat_sub(input logic [16:0] a,
                                         input logic [16:0] b);
    sat_sub = (a > b) ? 17'(a - b) : 17'h0_0000;
  endfunction

  // ----------------------------------------------------------------
  // Speed magnitudes
  // ----------------------------------------------------------------
  always_comb begin
    abs_speed = abs17(17'(speed_in));
    error_wide = 17'(speed_cmd_in) - 17'(speed_in);
    abs_error = abs17(error_wide);
  end

  // Levels per comparator; thresholds are magnitudes in rpm
  always_comb begin
    cmp_value[ssbs_pkg::CMP_ZERO] = abs_speed;
    cmp_on[ssbs_pkg::CMP_ZERO] =
      sat_sub({1'b0, s_reg.zero_speed_threshold}, 17'h0_0001);
    cmp_off[ssbs_pkg::CMP_ZERO] =
      17'({1'b0, s_reg.zero_speed_threshold} + ssbs_pkg::HYST_RPM)
      - 17'h0_0001;
    cmp_value[ssbs_pkg::CMP_MATCH] = abs_error;
    cmp_on[ssbs_pkg::CMP_MATCH] =
      sat_sub({1'b0, s_reg.speed_match_window}, ssbs_pkg::HYST_RPM);
    cmp_off[ssbs_pkg::CMP_MATCH] =
      17'({1'b0, s_reg.speed_match_window} + ssbs_pkg::HYST_RPM);
    cmp_value[ssbs_pkg::CMP_ARRIVAL] = abs_speed;
    cmp_on[ssbs_pkg::CMP_ARRIVAL] =
      {1'b0, s_reg.arrival_speed_threshold};
    cmp_off[ssbs_pkg::CMP_ARRIVAL] =
      sat_sub({1'b0, s_reg.arrival_speed_threshold},
              ssbs_pkg::HYST_RPM);
  end

  // ----------------------------------------------------------------
  // Status comparators
  // ----------------------------------------------------------------
  // Flags move only on a speed sample so they follow the control loop
  // and not intermediate values of the speed bus.
  generate
    for (genvar i = 0; i < ssbs_pkg::CMP_COUNT; i++) begin : g_cmp
      ssbs_hyst_cmp #(
        .WIDTH(17),
        .RISING(ssbs_pkg::CMP_RISING[i])
      ) u_cmp (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .update_in(speed_sample_in),
        .value_in(cmp_value[i]),
        .on_lvl_in(cmp_on[i]),
        .off_lvl_in(cmp_off[i]),
        .flag_out(cmp_flag[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Brake delay timer
  // ----------------------------------------------------------------
  ssbs_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(tmr_start),
    .abort_in(tmr_abort),
    .ms_in(tmr_ms),
    .done_out(tmr_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_ms = s_reg.standstill_brake_delay;
    below_engage = (abs_speed < {1'b0, s_reg.brake_engage_speed});

    // Parameter writes
    if (param_write_in) begin
      s_next.ack = 1'b1;
      if (param_index_in == ssbs_pkg::IDX_ZERO_THR) begin
        s_next.zero_speed_threshold = param_wdata_in;
      end else if (param_index_in == ssbs_pkg::IDX_MATCH_WIN) begin
        s_next.speed_match_window = param_wdata_in;
      end else if (param_index_in == ssbs_pkg::IDX_ARRIVAL_THR) begin
        s_next.arrival_speed_threshold = param_wdata_in;
      end else if (param_index_in == ssbs_pkg::IDX_STILL_DLY) begin
        s_next.standstill_brake_delay = param_wdata_in;
      end else if (param_index_in == ssbs_pkg::IDX_RUN_DLY) begin
        s_next.running_brake_delay = param_wdata_in;
      end else if (param_index_in == ssbs_pkg::IDX_ENGAGE_SPD) begin
        s_next.brake_engage_speed = param_wdata_in;
      end else if (param_index_in == ssbs_pkg::IDX_ESTOP_MODE) begin
        s_next.estop_mode = param_wdata_in[ssbs_pkg::ESTOP_MODE_BIT];
      end
    end else if (param_read_in) begin
      s_next.ack = 1'b1;
      if (param_index_in == ssbs_pkg::IDX_ZERO_THR) begin
        s_next.rdata = s_reg.zero_speed_threshold;
      end else if (param_index_in == ssbs_pkg::IDX_MATCH_WIN) begin
        s_next.rdata = s_reg.speed_match_window;
      end else if (param_index_in == ssbs_pkg::IDX_ARRIVAL_THR) begin
        s_next.rdata = s_reg.arrival_speed_threshold;
      end else if (param_index_in == ssbs_pkg::IDX_STILL_DLY) begin
        s_next.rdata = s_reg.standstill_brake_delay;
      end else if (param_index_in == ssbs_pkg::IDX_RUN_DLY) begin
        s_next.rdata = s_reg.running_brake_delay;
      end else if (param_index_in == ssbs_pkg::IDX_ENGAGE_SPD) begin
        s_next.rdata = s_reg.brake_engage_speed;
      end else if (param_index_in == ssbs_pkg::IDX_ESTOP_MODE) begin
        s_next.rdata = {15'h0000, s_reg.estop_mode};
      end else begin
        s_next.rdata = 16'h0000;
      end
    end

    // Emergency stop: stop request always, alarm only in mode 0
    s_next.fstop = estop_in;
    if (estop_in && s_reg.estop_mode == ssbs_pkg::ESTOP_MODE_ALARM) begin
      s_next.alarm = 1'b1;
    end else if (!servo_on_input_in) begin
      s_next.alarm = 1'b0;
    end
    // Mode 1 leaves the servo request untouched
    servo_req = servo_on_input_in && !s_reg.alarm &&
      !(estop_in && s_reg.estop_mode == ssbs_pkg::ESTOP_MODE_ALARM);

    s_next.alt_zero = cmp_flag[ssbs_pkg::CMP_ZERO];

    // ----------------------------------------------------------------
    // Servo-off sequencing
    // ----------------------------------------------------------------
    case (s_reg.state)
      ssbs_pkg::SSBS_ST_OFF: begin
        s_next.brake_rel = 1'b0;
        s_next.energise = 1'b0;
        if (servo_req) begin
          s_next.state = ssbs_pkg::SSBS_ST_ON;
          s_next.brake_rel = 1'b1;
          s_next.energise = 1'b1;
        end
      end
      ssbs_pkg::SSBS_ST_ON: begin
        if (!servo_req) begin
          tmr_start = 1'b1;
          if (cmp_flag[ssbs_pkg::CMP_ZERO]) begin
            // Brake engages first; motor holds until it bites
            tmr_ms = s_reg.standstill_brake_delay;
            s_next.brake_rel = 1'b0;
            s_next.state = ssbs_pkg::SSBS_ST_STILL_HOLD;
          end else begin
            tmr_ms = s_reg.running_brake_delay;
            s_next.state = ssbs_pkg::SSBS_ST_RUN_WAIT;
          end
        end
      end
      ssbs_pkg::SSBS_ST_STILL_HOLD: begin
        if (tmr_done) begin
          tmr_abort = 1'b1;
          s_next.energise = 1'b0;
          s_next.state = ssbs_pkg::SSBS_ST_OFF;
        end
      end
      ssbs_pkg::SSBS_ST_RUN_WAIT: begin
        // Brake closes at the earlier event; motor drops with it
        if (tmr_done || below_engage) begin
          tmr_abort = 1'b1;
          s_next.brake_rel = 1'b0;
          s_next.energise = 1'b0;
          s_next.state = ssbs_pkg::SSBS_ST_OFF;
        end
      end
      default: begin
        s_next.state = ssbs_pkg::SSBS_ST_OFF;
        s_next.brake_rel = 1'b0;
        s_next.energise = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.state <= ssbs_pkg::SSBS_ST_OFF;
      s_reg.zero_speed_threshold <= ssbs_pkg::RST_ZERO_THR;
      s_reg.speed_match_window <= ssbs_pkg::RST_MATCH_WIN;
      s_reg.arrival_speed_threshold <= ssbs_pkg::RST_ARRIVAL_THR;
      s_reg.standstill_brake_delay <= ssbs_pkg::RST_STILL_DLY;
      s_reg.running_brake_delay <= ssbs_pkg::RST_RUN_DLY;
      s_reg.brake_engage_speed <= ssbs_pkg::RST_ENGAGE_SPD;
      s_reg.estop_mode <= ssbs_pkg::RST_ESTOP_MODE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign param_rdata_out = s_reg.rdata;
  assign param_ack_out = s_reg.ack;
  assign zero_speed_flag_out = cmp_flag[ssbs_pkg::CMP_ZERO];
  assign alt_zero_speed_output_out = s_reg.alt_zero;
  assign speed_match_flag_out = cmp_flag[ssbs_pkg::CMP_MATCH];
  assign arrival_speed_flag_out = cmp_flag[ssbs_pkg::CMP_ARRIVAL];
  assign brake_release_output_out = s_reg.brake_rel;
  assign motor_energise_out = s_reg.energise;
  assign forced_stop_out = s_reg.fstop;
  assign emergency_stop_alarm_out = s_reg.alarm;

endmodule // ssbs_sequencer

// ===== ssbs_brake_model.sv
// Holding brake model with engagement lag and slip counter
`timescale 1ns/1ps
module ssbs_brake_model #(
  parameter int LAG_CYC = 6
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic brake_release_in,
  input wire logic motor_energise_in,
  output logic brake_held_out,
  output logic [7:0] slip_count_out
);
  int lag_reg;
  logic energise_reg;
  // ------------------------------------------------------------
  // Brake shoe: grips only LAG_CYC cycles after release drops
  // ------------------------------------------------------------
  assign brake_held_out = (lag_reg >= LAG_CYC);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lag_reg <= LAG_CYC;
      energise_reg <= 1'b0;
      slip_count_out <= 8'h00;
    end else begin
      if (brake_release_in) begin
        lag_reg <= 0;
      end else if (lag_reg < LAG_CYC) begin
        lag_reg <= lag_reg + 1;
      end
      energise_reg <= motor_energise_in;
      // Load drops if power goes before the shoe grips
      if (energise_reg && !motor_energise_in && !brake_held_out) begin
        slip_count_out <= slip_count_out + 8'h01;
      end
    end
  end
endmodule // ssbs_brake_model

// ===== ssbs_chk.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module ssbs_chk #(
  parameter int CYC_PER_MS = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic signed [15:0] speed_in,
  input wire logic signed [15:0] speed_cmd_in,
  input wire logic speed_sample_in,
  input wire logic servo_on_input_in,
  input wire logic estop_in,
  input wire logic [15:0] param_index_in,
  input wire logic [15:0] param_wdata_in,
  input wire logic param_write_in,
  input wire logic zero_speed_flag_out,
  input wire logic speed_match_flag_out,
  input wire logic arrival_speed_flag_out,
  input wire logic brake_release_output_out,
  input wire logic motor_energise_out,
  input wire logic forced_stop_out,
  input wire logic emergency_stop_alarm_out
);
  logic [15:0] zthr_reg, win_reg, athr_reg, rdly_reg, eng_reg;
  logic mode_reg;
  int run_cnt_reg;
  logic [16:0] sp, mag, dif, mdif;
  // ------------------------------------------------------------
  // Shadow parameters, so thresholds are judged as programmed
  // ------------------------------------------------------------
  assign sp = {speed_in[15], speed_in};
  assign mag = sp[16] ? -sp : sp;
  assign dif = {speed_cmd_in[15], speed_cmd_in} - sp;
  assign mdif = dif[16] ? -dif : dif;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zthr_reg <= ssbs_pkg::RST_ZERO_THR;
      win_reg <= ssbs_pkg::RST_MATCH_WIN;
      athr_reg <= ssbs_pkg::RST_ARRIVAL_THR;
      rdly_reg <= ssbs_pkg::RST_RUN_DLY;
      eng_reg <= ssbs_pkg::RST_ENGAGE_SPD;
      mode_reg <= ssbs_pkg::RST_ESTOP_MODE;
      run_cnt_reg <= 0;
    end else begin
      if (param_write_in) begin
        case (param_index_in)
          ssbs_pkg::IDX_ZERO_THR: zthr_reg <= param_wdata_in;
          ssbs_pkg::IDX_MATCH_WIN: win_reg <= param_wdata_in;
          ssbs_pkg::IDX_ARRIVAL_THR: athr_reg <= param_wdata_in;
          ssbs_pkg::IDX_RUN_DLY: rdly_reg <= param_wdata_in;
          ssbs_pkg::IDX_ENGAGE_SPD: eng_reg <= param_wdata_in;
          ssbs_pkg::IDX_ESTOP_MODE: mode_reg <= param_wdata_in[0];
          default: ;
        endcase
      end
      // Cycles with the brake still open after servo-on went away
      if (brake_release_output_out && !servo_on_input_in) begin
        run_cnt_reg <= run_cnt_reg + 1;
      end else begin
        run_cnt_reg <= 0;
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_zero_on: assert property (
    speed_sample_in && mag < zthr_reg |=> zero_speed_flag_out)
    else $error("zero flag not set");
  a_zero_off: assert property (
    speed_sample_in && mag > zthr_reg + 9 |=> !zero_speed_flag_out)
    else $error("zero flag not cleared");
  a_flags_hold: assert property (!speed_sample_in |=>
    $stable(zero_speed_flag_out) && $stable(speed_match_flag_out)
    && $stable(arrival_speed_flag_out)) else $error("flag moved");
  a_match_on: assert property (
    speed_sample_in && mdif + 10 <= win_reg |=> speed_match_flag_out)
    else $error("match flag not set");
  a_match_off: assert property (
    speed_sample_in && mdif > win_reg + 10 |=> !speed_match_flag_out)
    else $error("match flag not cleared");
  a_arrival_on: assert property (
    speed_sample_in && mag > athr_reg |=> arrival_speed_flag_out)
    else $error("arrival flag not set");
  a_arrival_off: assert property (
    speed_sample_in && mag + 10 < athr_reg |=> !arrival_speed_flag_out)
    else $error("arrival flag not cleared");
  a_brake_first: assert property ($fell(servo_on_input_in)
    && zero_speed_flag_out && brake_release_output_out && !estop_in
    && motor_energise_out |=> !brake_release_output_out
    && motor_energise_out) else $error("standstill order wrong");
  a_power_after: assert property (
    $fell(motor_energise_out) |-> !brake_release_output_out)
    else $error("power dropped with brake open");
  a_run_delay: assert property (
    run_cnt_reg <= int'(rdly_reg) * CYC_PER_MS + 3)
    else $error("running brake delay overrun");
  a_speed_exit: assert property (brake_release_output_out
    && !servo_on_input_in && !estop_in && mag < eng_reg
    |-> ##[1:3] !brake_release_output_out) else $error("brake late");
  a_estop_alarm: assert property (estop_in
    && mode_reg == ssbs_pkg::ESTOP_MODE_ALARM |=>
    emergency_stop_alarm_out && forced_stop_out) else $error("no alarm");
  a_estop_keep: assert property (estop_in && servo_on_input_in
    && mode_reg == ssbs_pkg::ESTOP_MODE_KEEP && motor_energise_out
    && !emergency_stop_alarm_out |=> forced_stop_out && motor_energise_out
    && !emergency_stop_alarm_out) else $error("keep mode wrong");
  c_match: cover property ($rose(speed_match_flag_out));
  c_run: cover property ($fell(brake_release_output_out)
    && $fell(motor_energise_out));
  c_estop: cover property (estop_in ##1 emergency_stop_alarm_out);
endmodule // ssbs_chk

bind ssbs_sequencer ssbs_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_i (.*);

// ===== speed_status_and_brake_sequencer_test.sv
// Self-checking bench for the speed status and brake sequencer
`timescale 1ns/1ps
module speed_status_and_brake_sequencer_test;
  localparam int CPM = 4;
  localparam int EM = 16'h2443;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic signed [15:0] speed_in = 16'h0000;
  logic signed [15:0] speed_cmd_in = 16'h0000;
  logic speed_sample_in = 1'b0;
  logic servo_on_input_in = 1'b0;
  logic estop_in = 1'b0;
  logic [15:0] param_index_in = 16'h0000;
  logic [15:0] param_wdata_in = 16'h0000;
  logic param_write_in = 1'b0;
  logic param_read_in = 1'b0;
  logic [15:0] param_rdata_out;
  logic param_ack_out, zero_speed_flag_out, alt_zero_speed_output_out;
  logic speed_match_flag_out, arrival_speed_flag_out, brake_held;
  logic brake_release_output_out, motor_energise_out;
  logic forced_stop_out, emergency_stop_alarm_out;
  logic [7:0] slip_count;
  logic [31:0] seed = 32'h0000_1c79;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int m_zero = 0, m_match = 0, m_arr = 0, s, nb, ne;
  int regs[int];
  int dflt[7] = '{50, 50, 1000, 0, 0, 30, 0};
  int setup[7][2] = '{'{16'h2434, 50}, '{16'h2435, 50}, '{16'h2436, 1000},
    '{16'h2437, 2}, '{16'h2438, 3}, '{16'h2439, 30}, '{EM, 0}};
  int tbl[14][2] = '{'{0, 0}, '{-49, -49}, '{59, 19}, '{-60, 0}, '{61, 0},
    '{45, 4}, '{-40, 0}, '{1000, 1000}, '{-1001, -1001}, '{990, 990},
    '{989, 0}, '{32767, -32768}, '{-32768, 0}, '{0, 0}};

  always #12.5 clk_in = ~clk_in;

  ssbs_sequencer #(.CYC_PER_MS(CPM)) uut (.*);

  ssbs_brake_model #(.LAG_CYC(6)) brake_i (
    .clk_in(clk_in), .rst_in(rst_in),
    .brake_release_in(brake_release_output_out),
    .motor_energise_in(motor_energise_out),
    .brake_held_out(brake_held), .slip_count_out(slip_count));

  // ------------------------------------------------------------
  // Bus, sample and servo tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? (v >> 1) ^ 32'h8020_0003 : v >> 1;
  endfunction
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input int idx, input int d);
    tick();
    param_index_in = 16'(idx);
    param_wdata_in = 16'(d);
    param_write_in = 1'b1;
    tick();
    param_write_in = 1'b0;
    chk(param_ack_out, 1);
    if (regs.exists(idx)) regs[idx] = (idx == EM) ? d & 1 : d & 16'hffff;
  endtask
  task automatic rd(input int idx);
    tick();
    param_index_in = 16'(idx);
    param_read_in = 1'b1;
    tick();
    param_read_in = 1'b0;
    chk(param_ack_out, 1);
    chk(param_rdata_out, regs.exists(idx) ? regs[idx] : 0);
  endtask
  // Model flags follow the on and off levels, the band in between holds
  task automatic samp(input int sp, input int cmd);
    int mag, dif, pz;
    tick();
    pz = m_zero;
    mag = sp < 0 ? -sp : sp;
    dif = cmd > sp ? cmd - sp : sp - cmd;
    speed_in = 16'(sp);
    speed_cmd_in = 16'(cmd);
    speed_sample_in = 1'b1;
    if (mag < regs[16'h2434]) m_zero = 1;
    else if (mag > regs[16'h2434] + 9) m_zero = 0;
    if (dif + 10 <= regs[16'h2435]) m_match = 1;
    else if (dif > regs[16'h2435] + 10) m_match = 0;
    if (mag > regs[16'h2436]) m_arr = 1;
    else if (mag + 10 < regs[16'h2436]) m_arr = 0;
    tick();
    speed_sample_in = 1'b0;
    chk(zero_speed_flag_out, m_zero);
    chk(speed_match_flag_out, m_match);
    chk(arrival_speed_flag_out, m_arr);
    chk(alt_zero_speed_output_out, pz);
  endtask
  task automatic on();
    tick();
    servo_on_input_in = 1'b1;
    tick();
    chk(brake_release_output_out, 1);
    chk(motor_energise_out, 1);
  endtask
  // Drops servo-on; at step cut the speed falls under the engage speed
  task automatic drop(input int cut, output int b, output int e);
    tick();
    servo_on_input_in = 1'b0;
    b = 0;
    e = 0;
    for (int n = 1; n < 100 && e == 0; n++) begin
      tick();
      if (n == cut) begin
        speed_in = 16'h000a;
        speed_sample_in = 1'b1;
        m_zero = 1;
      end
      if (n == cut + 1) speed_sample_in = 1'b0;
      if (b == 0 && brake_release_output_out === 1'b0) b = n;
      if (motor_energise_out === 1'b0) e = n;
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    foreach (setup[i]) regs[setup[i][0]] = dflt[i];
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    foreach (regs[k]) rd(k);
    wr(16'h2440, 16'h1234);
    rd(16'h2440);
    foreach (regs[k]) begin
      seed = lfsr(seed);
      wr(k, seed[15:0]);
      rd(k);
    end
    foreach (setup[i]) wr(setup[i][0], setup[i][1]);
    foreach (tbl[i]) samp(tbl[i][0], tbl[i][1]);
    repeat (40) begin
      seed = lfsr(seed);
      s = int'($signed(seed[11:0]));
      samp(s, s + int'(seed[22:16]) - 64);
    end
    tick();
    speed_in = 16'h0fa0;
    repeat (3) tick();
    chk(zero_speed_flag_out, m_zero);
    chk(arrival_speed_flag_out, m_arr);
    samp(0, 0);
    on();
    drop(0, nb, ne);
    chk(nb, 1);
    chk(ne, 2 * CPM + 2);
    chk(slip_count, 0);
    samp(500, 500);
    on();
    drop(0, nb, ne);
    chk(nb, 3 * CPM + 2);
    chk(ne, nb);
    on();
    drop(3, nb, ne);
    chk(nb <= 7, 1);
    chk(ne, nb);
    samp(500, 500);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) wr(EM, 1);
      on();
      tick();
      estop_in = 1'b1;
      tick();
      chk(forced_stop_out, 1);
      chk(emergency_stop_alarm_out, !m);
      repeat (16) tick();
      chk(motor_energise_out, m);
      chk(brake_release_output_out, m);
      estop_in = 1'b0;
      repeat (2) tick();
      chk(motor_energise_out, m);
      chk(emergency_stop_alarm_out, !m);
      servo_on_input_in = 1'b0;
      repeat (2) tick();
      chk(emergency_stop_alarm_out, 0);
    end
    results();
  end
endmodule // speed_status_and_brake_sequencer_test
